// ### hw/isx_defs.vh
// isx_defs.vh: constants for the indexed/stack extended instruction executor
// assumes a 16-bit instruction word, 12-bit data address, 8-bit data
`ifndef ISX_DEFS_VH
`define ISX_DEFS_VH

// ----------------------------------------------------------------------
// opcode prefixes
// ----------------------------------------------------------------------
`define ISX_OP_MOVE1 8'heb
`define ISX_OP_MOVE2 4'hf
`define ISX_OP_PUSH 8'hea
`define ISX_OP_SUB 8'he9
`define ISX_SEL_RET 2'h3

// ----------------------------------------------------------------------
// address map facts
// ----------------------------------------------------------------------
`define ISX_ADDR_W 12
`define ISX_OFS_LIMIT 8'h5f
`define ISX_ACCESS_HI_BASE 12'hf00
`define ISX_PCL_ADDR 12'hff9
`define ISX_RETURN_TOP_LOW_ADDR 12'hffd
`define ISX_RETURN_TOP_HIGH_ADDR 12'hffe
`define ISX_RETURN_TOP_UPPER_ADDR 12'hfff
`define ISX_INDF0_ADDR 12'hfef
`define ISX_INDF1_ADDR 12'hfe7
`define ISX_INDF2_ADDR 12'hddf
`define ISX_PTR_RESET 12'h000

`endif

// ### hw/isx_addr_calc.v
// isx_addr_calc.v: forms the effective address of a standard file operand
// assumes the bank select register comes from the core and the stack frame pointer from isx_exec
`timescale 1ns/1ns
`include "isx_defs.vh"

module isx_addr_calc (
  // operand fields
  input wire [7:0] file_i,
  input wire access_i,
  // core state
  input wire ext_en_i,
  input wire [3:0] bank_i,
  input wire [11:0] frame_ptr_i,
  // result
  output reg [11:0] addr_o,
  output reg indexed_o
);

  // ----------------------------------------------------------------------
  // operand mapping
  // ----------------------------------------------------------------------
  // one process picks direct, banked or indexed addressing
  always @* begin
    indexed_o = 1'b0;
    if (access_i) begin
      addr_o = {bank_i, file_i}; // banked
    end else if (ext_en_i && (file_i <= `ISX_OFS_LIMIT)) begin
      addr_o = frame_ptr_i + {4'h0, file_i};
      indexed_o = 1'b1;
    end else if (file_i <= `ISX_OFS_LIMIT) begin
      addr_o = {4'h0, file_i};
    end else begin
      addr_o = `ISX_ACCESS_HI_BASE | {4'h0, file_i};
    end
  end

endmodule

// ### hw/isx_exec.v
// isx_exec.v: decode and execute of indexed move, push, pointer subtract
// assumes one instruction word presented per cycle with a valid strobe,
// a data memory with combinational read and synchronous write outside
//
// How it works
// - indexed move: two words, two cycles
// - move addresses are pointer plus offset
// - move never writes program counter/return bytes
// - indirect source reads back zero
// - indirect destination makes move a no-op
// - push writes literal then decrements pointer
// - push opcode upper byte 1110 1010
// - subtract 6-bit literal from pointer 0..2
// - subtract opcode prefix 1110 1001
// - select 11: frame pointer subtract, return
// - subtract-and-return takes two cycles
// - extended enable also turns on indexing
// - low access operand offsets frame pointer
// - disabled: direct access or banked address
// - operands above 5Fh keep access bank
// - zero frame pointer matches access bank
// - destination bit decoded as normal
// - enable bit defaults zero, both off
`timescale 1ns/1ns
`include "isx_defs.vh"

module isx_exec (
  // clock and reset
  input wire SYS_CLK_I,
  input wire RST_I,
  // configuration
  input wire EXT_EN_I,
  // instruction stream
  input wire INSTR_VALID_I,
  input wire [15:0] INSTR_I,
  // core state for standard operands and return
  input wire [3:0] BANK_I,
  input wire [20:0] RET_TOP_I,
  // data memory
  input wire [7:0] MEM_RDATA_I,
  output wire [11:0] MEM_RADDR_O,
  output reg [11:0] MEM_WADDR_O,
  output reg [7:0] MEM_WDATA_O,
  output reg MEM_WE_O,
  // standard operand mapping
  output wire [11:0] STD_ADDR_O,
  output wire STD_INDEXED_O,
  output wire STD_DEST_FILE_O,
  // control back to the core
  output reg PC_LOAD_O,
  output reg [20:0] PC_NEXT_O,
  output wire BUSY_O,
  output wire EXT_HIT_O,
  // pointers
  output wire [11:0] PTR0_O,
  output wire [11:0] PTR1_O,
  output wire [11:0] FRAME_PTR_O
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_MOVE2 = 2'b01;
  localparam ST_RETNOP = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [11:0] ptr_q [0:2];
  reg [11:0] ptr0_d;
  reg [11:0] ptr1_d;
  reg [11:0] ptr2_d;
  reg [7:0] src_data_q;
  reg [7:0] src_data_d;
  reg [7:0] wdata_d;
  reg [11:0] waddr_d;
  reg we_d;
  reg pc_load_d;
  reg [20:0] pc_next_d;
  reg ext_en_q;
  reg [11:0] raddr;
  reg hit;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // pointer plus 7-bit offset, wrapping at twelve bits
  function [11:0] isx_index;
    input [11:0] base;
    input [6:0] ofs;
    begin
      isx_index = base + {5'h00, ofs};
    end
  endfunction

  // address is one of the indirect access registers
  function isx_is_indirect;
    input [11:0] a;
    begin
      isx_is_indirect = (a == `ISX_INDF0_ADDR) || (a == `ISX_INDF1_ADDR) ||
        (a == `ISX_INDF2_ADDR);
    end
  endfunction

  // address is program counter low or a return stack byte
  function isx_is_protected;
    input [11:0] a;
    begin
      isx_is_protected = (a == `ISX_PCL_ADDR) || (a == `ISX_RETURN_TOP_LOW_ADDR) ||
        (a == `ISX_RETURN_TOP_HIGH_ADDR) || (a == `ISX_RETURN_TOP_UPPER_ADDR);
    end
  endfunction

  wire [7:0] op_hi = INSTR_I[15:8];
  wire [1:0] sel = INSTR_I[7:6];
  wire [11:0] lit6 = {6'h00, INSTR_I[5:0]};
  wire [11:0] frame_ptr = ptr_q[2];

  // ----------------------------------------------------------------------
  // standard operand mapping
  // ----------------------------------------------------------------------
  // extended enable drives indexing
  isx_addr_calc u_addr (
    .file_i(INSTR_I[7:0]),
    .access_i(INSTR_I[8]),
    .ext_en_i(ext_en_q),
    .bank_i(BANK_I),
    .frame_ptr_i(frame_ptr),
    .addr_o(STD_ADDR_O),
    .indexed_o(STD_INDEXED_O)
  );

  assign STD_DEST_FILE_O = INSTR_I[9];

  // ----------------------------------------------------------------------
  // decode and execute
  // ----------------------------------------------------------------------
  // next state, pointer updates and memory write
  always @* begin
    state_d = ST_IDLE;
    ptr0_d = ptr_q[0];
    ptr1_d = ptr_q[1];
    ptr2_d = ptr_q[2];
    src_data_d = src_data_q;
    wdata_d = 8'h00;
    waddr_d = 12'h000;
    we_d = 1'b0;
    pc_load_d = 1'b0;
    pc_next_d = PC_NEXT_O;
    raddr = 12'h000;
    hit = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (INSTR_VALID_I && ext_en_q) begin
          if (op_hi == `ISX_OP_MOVE1 && INSTR_I[7]) begin
            hit = 1'b1;
            raddr = isx_index(frame_ptr, INSTR_I[6:0]);
            src_data_d = isx_is_indirect(raddr) ? 8'h00 : MEM_RDATA_I;
            state_d = ST_MOVE2;
          end else if (op_hi == `ISX_OP_PUSH) begin
            hit = 1'b1;
            we_d = 1'b1;
            waddr_d = frame_ptr;
            wdata_d = INSTR_I[7:0];
            ptr2_d = frame_ptr - 12'h001;
          end else if (op_hi == `ISX_OP_SUB) begin
            hit = 1'b1;
            if (sel == `ISX_SEL_RET) begin
              ptr2_d = frame_ptr - lit6;
              pc_load_d = 1'b1;
              pc_next_d = RET_TOP_I;
              state_d = ST_RETNOP;
            end else begin
              if (sel == 2'd0) begin
                ptr0_d = ptr_q[0] - lit6;
              end else if (sel == 2'd1) begin
                ptr1_d = ptr_q[1] - lit6;
              end else begin
                ptr2_d = frame_ptr - lit6;
              end
            end
          end
        end
      end
      ST_MOVE2: begin
        hit = 1'b1;
        if (INSTR_VALID_I) begin
          if (INSTR_I[15:12] == `ISX_OP_MOVE2) begin
            waddr_d = isx_index(frame_ptr, INSTR_I[6:0]);
            wdata_d = src_data_q;
            we_d = !isx_is_indirect(waddr_d) && !isx_is_protected(waddr_d);
          end
        end else begin
          state_d = ST_MOVE2; // wait for second word
        end
      end
      ST_RETNOP: begin
        hit = 1'b1;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  assign MEM_RADDR_O = raddr;
  assign BUSY_O = (state_q != ST_IDLE);
  assign EXT_HIT_O = hit;
  assign PTR0_O = ptr_q[0];
  assign PTR1_O = ptr_q[1];
  assign FRAME_PTR_O = ptr_q[2];

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  // state, pointers and registered outputs
  always @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      state_q <= ST_IDLE;
      ptr_q[0] <= `ISX_PTR_RESET;
      ptr_q[1] <= `ISX_PTR_RESET;
      ptr_q[2] <= `ISX_PTR_RESET;
      src_data_q <= 8'h00;
      MEM_WADDR_O <= 12'h000;
      MEM_WDATA_O <= 8'h00;
      MEM_WE_O <= 1'b0;
      PC_LOAD_O <= 1'b0;
      PC_NEXT_O <= 21'h000000;
      ext_en_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ptr_q[0] <= ptr0_d;
      ptr_q[1] <= ptr1_d;
      ptr_q[2] <= ptr2_d;
      src_data_q <= src_data_d;
      MEM_WADDR_O <= waddr_d;
      MEM_WDATA_O <= wdata_d;
      MEM_WE_O <= we_d;
      PC_LOAD_O <= pc_load_d;
      PC_NEXT_O <= pc_next_d;
      ext_en_q <= EXT_EN_I;
    end
  end

endmodule

// ### dv/isx_exec_props.sv
// isx_exec_props.sv: port assertions for the extended executor
// assumes isx_defs.vh on the include path, bound to isx_exec
`timescale 1ns/1ns
`include "isx_defs.vh"
module isx_props (
  // watched ports
  input wire SYS_CLK_I,
  input wire RST_I,
  input wire EXT_EN_I,
  input wire INSTR_VALID_I,
  input wire [15:0] INSTR_I,
  input wire [3:0] BANK_I,
  input wire [20:0] RET_TOP_I,
  input wire [11:0] MEM_RADDR_O,
  input wire [11:0] MEM_WADDR_O,
  input wire [7:0] MEM_WDATA_O,
  input wire MEM_WE_O,
  input wire [11:0] STD_ADDR_O,
  input wire STD_INDEXED_O,
  input wire STD_DEST_FILE_O,
  input wire PC_LOAD_O,
  input wire [20:0] PC_NEXT_O,
  input wire BUSY_O,
  input wire EXT_HIT_O,
  input wire [11:0] PTR0_O,
  input wire [11:0] FRAME_PTR_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  // ----------------------------------------------------------------
  // helpers: enable flop mirror, decode of taken words
  // ----------------------------------------------------------------
  reg en_q;
  always @(posedge SYS_CLK_I) en_q <= RST_I ? 1'b0 : EXT_EN_I;
  wire tk = INSTR_VALID_I && en_q && !BUSY_O;
  wire [7:0] op = INSTR_I[15:8];
  wire [7:0] f = INSTR_I[7:0];
  wire rt = tk && op == `ISX_OP_SUB && INSTR_I[7:6] == `ISX_SEL_RET;
  wire lo = en_q && !INSTR_I[8] && f <= `ISX_OFS_LIMIT;
  a_push_write: assert property (
    tk && op == `ISX_OP_PUSH |=> MEM_WE_O && MEM_WDATA_O == $past(f) &&
    MEM_WADDR_O == $past(FRAME_PTR_O) && FRAME_PTR_O == $past(FRAME_PTR_O) - 12'h1)
    else $error("push result wrong");
  a_sub_ptr: assert property (
    tk && op == `ISX_OP_SUB && INSTR_I[7:6] == 2'h0 |=>
    PTR0_O == $past(PTR0_O) - {6'h0, $past(INSTR_I[5:0])})
    else $error("pointer subtract wrong");
  a_ret_load: assert property (
    rt |=> PC_LOAD_O && PC_NEXT_O == $past(RET_TOP_I) &&
    FRAME_PTR_O == $past(FRAME_PTR_O) - {6'h0, $past(INSTR_I[5:0])})
    else $error("return load wrong");
  a_ret_cycles: assert property (
    rt |=> BUSY_O ##1 !BUSY_O && !PC_LOAD_O)
    else $error("return length wrong");
  a_move_src: assert property (
    tk && INSTR_I[15:7] == {`ISX_OP_MOVE1, 1'b1} |->
    MEM_RADDR_O == FRAME_PTR_O + {5'h0, INSTR_I[6:0]} ##1 BUSY_O)
    else $error("move source wrong");
  a_move_safe: assert property (
    MEM_WE_O && $past(BUSY_O) |-> !(MEM_WADDR_O inside {`ISX_PCL_ADDR,
    `ISX_RETURN_TOP_LOW_ADDR, `ISX_RETURN_TOP_HIGH_ADDR, `ISX_RETURN_TOP_UPPER_ADDR, `ISX_INDF0_ADDR,
    `ISX_INDF1_ADDR, `ISX_INDF2_ADDR}))
    else $error("move wrote a guarded byte");
  a_ext_off: assert property (
    !en_q && !BUSY_O |-> !EXT_HIT_O)
    else $error("extended op while off");
  a_std_index: assert property (
    en_q == EXT_EN_I && lo |-> STD_INDEXED_O && STD_ADDR_O == FRAME_PTR_O + {4'h0, f})
    else $error("indexed operand wrong");
  a_std_direct: assert property (
    en_q == EXT_EN_I && !lo |-> !STD_INDEXED_O && STD_ADDR_O == (INSTR_I[8] ?
    {BANK_I, f} : (f > `ISX_OFS_LIMIT ? (`ISX_ACCESS_HI_BASE | {4'h0, f}) : {4'h0, f})))
    else $error("direct operand wrong");
  a_dest_bit: assert property (
    STD_DEST_FILE_O == INSTR_I[9])
    else $error("destination bit wrong");
endmodule
bind isx_exec isx_props u_props (.*);

// ### dv/testbench.sv
// testbench.sv: directed checks of the extended executor
// assumes a memory whose read data is its address xor 5ah
`timescale 1ns/1ns
module testbench;
  reg clk = 0, rst = 1, en = 0, vld = 0;
  reg [15:0] ins = 16'h0000;
  reg [3:0] bank = 4'h3;
  reg [20:0] ret = 21'h1abcd;
  wire [11:0] raddr, waddr, saddr, p0, p1, fp;
  wire hit;
  wire [7:0] rd, wdata;
  wire [20:0] pcn;
  wire we, sidx, sdst, program_counter_low, busy;
  integer n_mismatch = 0, checked = 0;
  assign rd = raddr[7:0] ^ 8'h5a;
  initial forever #20 clk = ~clk;
  isx_exec dut (.SYS_CLK_I(clk), .RST_I(rst), .EXT_EN_I(en), .INSTR_VALID_I(vld),
    .INSTR_I(ins), .BANK_I(bank), .RET_TOP_I(ret), .MEM_RDATA_I(rd),
    .MEM_RADDR_O(raddr), .MEM_WADDR_O(waddr), .MEM_WDATA_O(wdata), .MEM_WE_O(we),
    .STD_ADDR_O(saddr), .STD_INDEXED_O(sidx), .STD_DEST_FILE_O(sdst),
    .PC_LOAD_O(program_counter_low), .PC_NEXT_O(pcn), .BUSY_O(busy), .EXT_HIT_O(hit),
    .PTR0_O(p0), .PTR1_O(p1), .FRAME_PTR_O(fp));
  // ----------------------------------------------------------------
  // shared compare and drive tasks
  // ----------------------------------------------------------------
  task chk(input string nm, input [20:0] e, input [20:0] g);
    begin
      checked = checked + 1;
      if (e !== g) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task send(input [15:0] w);
    begin
      @(posedge clk);
      #1 ins = w;
      vld = 1;
      @(posedge clk);
      #1 vld = 0;
    end
  endtask
  task mv(input [6:0] s, input [6:0] d, input e, input [11:0] a, input [7:0] v);
    begin
      send({8'heb, 1'b1, s});
      send({4'hf, 5'h0, d});
      chk("we", e, we);
      if (e) chk("waddr", a, waddr);
      if (e) chk("wdata", v, wdata);
    end
  endtask
  task sa(input [15:0] w, input [11:0] a, input x);
    begin
      @(posedge clk);
      #1 ins = w;
      #1 chk("std addr", a, saddr);
      chk("std indexed", x, sidx);
      chk("std dest", w[9], sdst);
    end
  endtask
  task complete_run;
    begin
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // push ignored while disabled, zero frame pointer indexing
  task t_disabled;
    begin
      send(16'hea08);
      chk("we off", 0, we);
      chk("fp off", 0, fp);
      en = 1;
      repeat (2) @(posedge clk);
      sa(16'h2610, 12'h010, 1);
      $display("disabled test done");
    end
  endtask
  // subtract from each pointer, wrapping below zero
  task t_subtract;
    integer i;
    begin
      for (i = 0; i < 3; i = i + 1)
        send({8'he9, i[1:0], 6'h3f});
      chk("p0", 12'hfc1, p0);
      chk("p1", 12'hfc1, p1);
      chk("fp", 12'hfc1, fp);
      $display("subtract test done");
    end
  endtask
  // push literal at frame pointer
  task t_push;
    begin
      send(16'hea08);
      chk("we", 1, we);
      chk("waddr", 12'hfc1, waddr);
      chk("wdata", 8'h08, wdata);
      chk("fp", 12'hfc0, fp);
      $display("push test done");
    end
  endtask
  // subtract and return, word in the ST_RETNOP cycle ignored
  task t_return;
    begin
      @(posedge clk);
      #1 ins = 16'he9c5;
      vld = 1;
      @(posedge clk);
      #1 ins = 16'hea77;
      chk("pc load", 1, program_counter_low);
      chk("pc next", ret, pcn);
      chk("fp", 12'hfbb, fp);
      chk("p0", 12'hfc1, p0);
      chk("busy", 1, busy);
      chk("hit", 1, hit);
      @(posedge clk);
      #1 vld = 0;
      chk("busy", 0, busy);
      chk("pc load", 0, program_counter_low);
      chk("we", 0, we);
      $display("return test done");
    end
  endtask
  // indexed moves, guarded and indirect destinations
  task t_move;
    begin
      mv(7'h05, 7'h7f, 1, 12'h03a, 8'h9a);
      mv(7'h34, 7'h01, 1, 12'hfbc, 8'h00);
      mv(7'h05, 7'h3e, 0, 0, 0);
      mv(7'h05, 7'h42, 0, 0, 0);
      mv(7'h05, 7'h43, 0, 0, 0);
      mv(7'h05, 7'h44, 0, 0, 0);
      mv(7'h05, 7'h2c, 0, 0, 0);
      $display("move test done");
    end
  endtask
  // standard operand mapping with and without the extension
  task t_operand;
    begin
      sa(16'h2610, 12'hfcb, 1);
      sa(16'h245f, 12'h01a, 1);
      sa(16'h2460, 12'hf60, 0);
      sa(16'h2510, 12'h310, 0);
      en = 0;
      repeat (2) @(posedge clk);
      sa(16'h2610, 12'h010, 0);
      $display("operand test done");
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 0;
    t_disabled;
    t_subtract;
    t_push;
    t_return;
    t_move;
    t_operand;
    complete_run;
  end
endmodule
